/* fdrs_top.sv */
// Rate select, input status and status byte zero registers behind an APB slave.
`timescale 1ns/1ps
`include "fdrs_map.svh"
module fdrs_top import fdrs_pkg::*; (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Lane enables of the host data bus, low while driven.
   output logic [7:0] bus_oe_n,
   // Configuration and drive side.
   input wire fdrs_mode_type mode_select,
   input wire logic media_changed,
   input wire logic transfer_engine_gate,
   output logic media_density_pin,
   output logic [1:0] rate_choice,
   // Command engine side.
   input wire logic recal_active,
   input wire logic step_pulse,
   input wire logic track_zero_pin,
   input wire logic relseek_past_zero,
   input wire logic result_strobe,
   input wire fdrs_result_type result_info,
   // Interrupt.
   output logic irq
);
   logic setup;
   logic wr_done;
   logic hit_status;
   logic hit_result;
   logic hit_int_status;
   logic hit_int_mask;
   logic mapped;
   logic precomp_off_flag;
   logic low_density_flag;
   logic [7:0] input_status;
   logic [7:0] next_oe_n;
   logic [31:0] next_prdata;
   logic [`FDRS_INT_WIDTH-1:0] int_status;
   logic [`FDRS_INT_WIDTH-1:0] int_mask;
   logic [`FDRS_INT_WIDTH-1:0] int_events;
   logic [`FDRS_INT_WIDTH-1:0] next_int_status;
   fdrs_status0_type status_zero;
   logic fault_event;
   logic seek_event;
   logic result_event;

   fdrs_status0 u_status0 (
      .clk(clk),
      .resetn(resetn),
      .soft_reset(soft_reset),
      .recal_active(recal_active),
      .step_pulse(step_pulse),
      .track_zero_pin(track_zero_pin),
      .relseek_past_zero(relseek_past_zero),
      .result_strobe(result_strobe),
      .result_info(result_info),
      .status_zero(status_zero),
      .fault_event(fault_event)
   );

   // Address decode; the upper address bits must be zero for a hit.
   assign setup = psel && !penable;
   assign wr_done = psel && penable && pready && pwrite;

   always_comb begin
      hit_status = 1'b0;
      hit_result = 1'b0;
      hit_int_status = 1'b0;
      hit_int_mask = 1'b0;
      if (paddr[31:14] != 18'h0_0000 || paddr[1:0] != 2'h0) begin
         hit_status = 1'b0;
      end else if (paddr[13:2] == `FDRS_IDX_INPUT_STATUS) begin
         hit_status = 1'b1;
      end else if (paddr[13:2] == `FDRS_IDX_RESULT_ZERO) begin
         hit_result = 1'b1;
      end else if (paddr[13:2] == `FDRS_IDX_INT_STATUS) begin
         hit_int_status = 1'b1;
      end else if (paddr[13:2] == `FDRS_IDX_INT_MASK) begin
         hit_int_mask = 1'b1;
      end
   end

   assign mapped = hit_status || hit_result || hit_int_status || hit_int_mask;

   // One wait-free access phase: ready follows every setup cycle.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
      end
   end

   // Rate choice only answers a hardware reset.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rate_choice <= `FDRS_RATE_RESET;
      end else if (wr_done && hit_status) begin
         rate_choice <= pwdata[`FDRS_RATE_LSB +: 2];
      end
   end

   // The flag has no effect on the write path; it is kept only to be read back.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         precomp_off_flag <= 1'b0;
      end else if (wr_done && hit_status && mode_select == FDRS_MODE_C) begin
         precomp_off_flag <= pwdata[`FDRS_PRECOMP_BIT];
      end
   end

   // The density pin is refreshed from rate writes only, so it stays high until one.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         media_density_pin <= 1'b1;
      end else if (wr_done && hit_status) begin
         media_density_pin <= pwdata[`FDRS_RATE_LSB +: 2] == `FDRS_RATE_500K ||
                              pwdata[`FDRS_RATE_LSB +: 2] == `FDRS_RATE_1M;
      end
   end

   assign low_density_flag = !(rate_choice == `FDRS_RATE_500K ||
                               rate_choice == `FDRS_RATE_1M);

   // Read layout per mode.
   always_comb begin
      input_status = 8'h00;
      next_oe_n = 8'hff;
      input_status[`FDRS_CHANGED_BIT] = !media_changed;
      case (mode_select)
         FDRS_MODE_B: begin
            input_status[0] = low_density_flag;
            input_status[2:1] = rate_choice;
            input_status[6:3] = `FDRS_B_ONES;
            next_oe_n = 8'h00;
         end
         FDRS_MODE_C: begin
            input_status[1:0] = rate_choice;
            input_status[`FDRS_PRECOMP_BIT] = precomp_off_flag;
            input_status[`FDRS_GATE_BIT_C] = transfer_engine_gate;
            next_oe_n = 8'h00;
         end
         default: begin
            next_oe_n = {1'b0, `FDRS_MODE_A_HIZ};
         end
      endcase
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_status) begin
         next_prdata = {24'h00_0000, input_status};
      end else if (hit_result) begin
         next_prdata = {24'h00_0000, status_zero};
      end else if (hit_int_status) begin
         next_prdata = {29'h0000_0000, int_status};
      end else if (hit_int_mask) begin
         next_prdata = {29'h0000_0000, int_mask};
      end
   end

   // Lanes are released at the access edge, so they never outlive the transfer on the bus.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
         bus_oe_n <= 8'hff;
      end else if (setup && !pwrite) begin
         prdata <= next_prdata;
         bus_oe_n <= hit_status ? next_oe_n : 8'h00;
      end else if (setup) begin
         prdata <= 32'h0000_0000;
         bus_oe_n <= 8'hff;
      end else begin
         bus_oe_n <= 8'hff;
      end
   end

   // Interrupt events; a set in the same cycle as its clear wins.
   assign seek_event = result_strobe && result_info.positioning_done;
   assign result_event = result_strobe;
   always_comb begin
      int_events = '0;
      int_events[`FDRS_INT_FAULT] = fault_event;
      int_events[`FDRS_INT_SEEK] = seek_event;
      int_events[`FDRS_INT_RESULT] = result_event;
      next_int_status = int_status;
      if (wr_done && hit_int_status) begin
         next_int_status = int_status & ~pwdata[`FDRS_INT_WIDTH-1:0];
      end
      next_int_status = next_int_status | int_events;
   end

   always_ff @(posedge clk) begin
      if (!resetn || soft_reset) begin
         int_status <= '0;
      end else begin
         int_status <= next_int_status;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         int_mask <= '0;
      end else if (wr_done && hit_int_mask) begin
         int_mask <= pwdata[`FDRS_INT_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   status_read_a: assert property (setup && !pwrite && hit_status |=>
      pready && !pslverr && prdata[31:8] == 24'h00_0000)
      else $error("input status read answered wrongly");
   hiz_lanes_a: assert property (setup && !pwrite && hit_status &&
      mode_select == FDRS_MODE_A |=> bus_oe_n == 8'h7f && prdata[6:0] == 7'h00)
      else $error("mode A lanes not released");
   changed_bit_a: assert property (setup && !pwrite && hit_status |=>
      prdata[7] == !$past(media_changed))
      else $error("media changed bit not inverted");
   density_bit_a: assert property (setup && !pwrite && hit_status &&
      mode_select == FDRS_MODE_B |=> prdata[0] == ($past(rate_choice) inside {2'h1, 2'h2}))
      else $error("low density bit wrong");
   mode_b_a: assert property (setup && !pwrite && hit_status &&
      mode_select == FDRS_MODE_B |=> prdata[6:1] == {4'hf, $past(rate_choice)})
      else $error("mode B layout wrong");
   soft_keep_a: assert property (soft_reset && !wr_done |=>
      $stable(rate_choice) && $stable(precomp_off_flag))
      else $error("software reset disturbed rate or flag");
   mode_c_a: assert property (setup && !pwrite && hit_status &&
      mode_select == FDRS_MODE_C |=> prdata[6:4] == 3'h0 && prdata[1:0] == $past(rate_choice))
      else $error("mode C layout wrong");
   gate_mirror_a: assert property (setup && !pwrite && hit_status &&
      mode_select == FDRS_MODE_C |=> prdata[3] == $past(transfer_engine_gate))
      else $error("gate bit not mirrored");
   precomp_read_a: assert property (setup && !pwrite && hit_status &&
      mode_select == FDRS_MODE_C |=> prdata[2] == $past(precomp_off_flag))
      else $error("precomp flag not mirrored");
   rate_write_a: assert property (wr_done && hit_status |=>
      rate_choice == $past(pwdata[1:0]))
      else $error("rate write lost");
   precomp_store_a: assert property (wr_done && hit_status &&
      mode_select != FDRS_MODE_C |=> $stable(precomp_off_flag))
      else $error("precomp flag written outside mode C");
   density_pin_a: assert property (wr_done && hit_status |=>
      media_density_pin == ($past(pwdata[1:0]) inside {2'h0, 2'h3}) ##1 $stable(media_density_pin) || $past(wr_done))
      else $error("density pin wrong after rate write");
   result_read_a: assert property (setup && !pwrite && hit_result |=>
      prdata[7:0] == $past(status_zero))
      else $error("status byte zero not presented");
   irq_level_a: assert property (|(int_status & int_mask) |=> irq)
      else $error("interrupt not raised");
   irq_quiet_a: assert property (!(|(int_status & int_mask)) |=> !irq)
      else $error("interrupt raised without an unmasked event");
endmodule : fdrs_top

/* fdrs_map.svh */
// Register offsets, field positions, reset values and counts for the rate select block.
`ifndef FDRS_MAP_SVH
`define FDRS_MAP_SVH
`define FDRS_IDX_INPUT_STATUS 12'h3f7
`define FDRS_IDX_RESULT_ZERO 12'h3f0
`define FDRS_IDX_INT_STATUS 12'h3f1
`define FDRS_IDX_INT_MASK 12'h3f2
`define FDRS_RATE_LSB 0
`define FDRS_PRECOMP_BIT 2
`define FDRS_CHANGED_BIT 7
`define FDRS_GATE_BIT_C 3
`define FDRS_RATE_RESET 2'h2
`define FDRS_RATE_500K 2'h0
`define FDRS_RATE_1M 2'h3
`define FDRS_B_ONES 4'hf
`define FDRS_MODE_A_HIZ 7'h7f
`define FDRS_INT_FAULT 0
`define FDRS_INT_SEEK 1
`define FDRS_INT_RESULT 2
`define FDRS_INT_WIDTH 3
`define FDRS_RECAL_STEPS 7'h50
`endif

/* fdrs_pkg.sv */
// Types shared by the rate select block and its status byte encoder.
package fdrs_pkg;
   typedef enum logic [2:0] {
      FDRS_MODE_A = 3'h1,
      FDRS_MODE_B = 3'h2,
      FDRS_MODE_C = 3'h4
   } fdrs_mode_type;

   typedef struct packed {
      logic [1:0] termination_code;
      logic positioning_done;
      logic head;
      logic [1:0] unit_number;
   } fdrs_result_type;

   typedef struct packed {
      logic [1:0] termination_code;
      logic positioning_done;
      logic equipment_fault;
      logic unused_zero;
      logic head;
      logic [1:0] unit_number;
   } fdrs_status0_type;
endpackage : fdrs_pkg

/* fdrs_status0.sv */
// Status byte zero encoder with the recalibrate step watchdog.
`timescale 1ns/1ps
`include "fdrs_map.svh"
module fdrs_status0 import fdrs_pkg::*; (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   // Positioning activity.
   input wire logic recal_active,
   input wire logic step_pulse,
   input wire logic track_zero_pin,
   input wire logic relseek_past_zero,
   // Result capture.
   input wire logic result_strobe,
   input wire fdrs_result_type result_info,
   output fdrs_status0_type status_zero,
   output logic fault_event
);
   logic [6:0] step_count;
   logic fault_flag;
   logic fault_now;

   // The watchdog fires once, on the step that reaches the limit without track zero.
   assign fault_now = (recal_active && step_pulse && !track_zero_pin &&
                       step_count == `FDRS_RECAL_STEPS - 7'h01) || relseek_past_zero;

   always_ff @(posedge clk) begin
      if (!resetn || soft_reset || !recal_active) begin
         step_count <= 7'h00;
      end else if (step_pulse && step_count != `FDRS_RECAL_STEPS) begin
         step_count <= step_count + 7'h01;
      end
   end

   // A fault arriving with the capture is kept for the byte being captured.
   always_ff @(posedge clk) begin
      if (!resetn || soft_reset) begin
         fault_flag <= 1'b0;
      end else if (result_strobe) begin
         fault_flag <= 1'b0;
      end else if (fault_now) begin
         fault_flag <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fault_event <= 1'b0;
      end else begin
         fault_event <= fault_now;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || soft_reset) begin
         status_zero <= '0;
      end else if (result_strobe) begin
         status_zero.termination_code <= result_info.termination_code;
         status_zero.positioning_done <= result_info.positioning_done;
         status_zero.equipment_fault <= fault_flag || fault_now;
         status_zero.unused_zero <= 1'b0;
         status_zero.head <= result_info.head;
         status_zero.unit_number <= result_info.unit_number;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   code_capture_a: assert property (result_strobe && !soft_reset |=>
      status_zero.termination_code == $past(result_info.termination_code))
      else $error("termination code not captured");
   seek_end_a: assert property (result_strobe && !soft_reset |=>
      status_zero.positioning_done == $past(result_info.positioning_done))
      else $error("seek end bit not captured");
   fault_sticky_a: assert property (fault_now && !soft_reset ##1 result_strobe && !soft_reset
      |=> status_zero.equipment_fault)
      else $error("equipment fault lost");
   drive_head_a: assert property (result_strobe && !soft_reset |=>
      status_zero.unused_zero == 1'b0 && status_zero.head == $past(result_info.head) &&
      status_zero.unit_number == $past(result_info.unit_number))
      else $error("drive select or zero bit wrong");
endmodule : fdrs_status0

/* fdrs_host.sv */
// Host processor model that issues APB transfers to the rate select block.
`timescale 1ns/1ps
module fdrs_host (
   // Clock.
   input wire logic clk,
   // APB request.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   // APB answer and data lane enables.
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] bus_oe_n
);
   logic [31:0] last_data;
   logic last_err;
   logic [7:0] last_oe;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
   end

   // The request stands unchanged until pready is seen high; only the watchdog ends a hang.
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      last_data = prdata;
      last_err = pslverr;
      last_oe = bus_oe_n;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // Reserved control bits always go out as zero.
   task automatic rate_write(input logic mode_c, input logic [1:0] rate, input logic precomp);
      xfer(1'b1, 32'h0000_0fdc, {24'h00_0000, 5'h00, mode_c & precomp, rate});
   endtask : rate_write
endmodule : fdrs_host

/* testbench.sv */
// Self-checking testbench for the rate select, input status and status byte block.
`timescale 1ns/1ps
`include "fdrs_map.svh"
`define CHECK(got, exp) begin \
   num_checks++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); \
   end \
end
module testbench import fdrs_pkg::*;;
   logic clk, resetn, soft_reset, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic [7:0] bus_oe_n;
   fdrs_mode_type mode_select;
   logic media_changed, transfer_engine_gate, media_density_pin, irq;
   logic [1:0] rate_choice;
   logic recal_active, step_pulse, track_zero_pin, relseek_past_zero, result_strobe;
   fdrs_result_type result_info;
   int fails = 0;
   int num_checks = 0;
   localparam logic [31:0] addr_in = {18'h0_0000, `FDRS_IDX_INPUT_STATUS, 2'b00};
   localparam logic [31:0] addr_res = {18'h0_0000, `FDRS_IDX_RESULT_ZERO, 2'b00};
   localparam logic [31:0] addr_ist = {18'h0_0000, `FDRS_IDX_INT_STATUS, 2'b00};
   localparam logic [31:0] addr_msk = {18'h0_0000, `FDRS_IDX_INT_MASK, 2'b00};

   fdrs_top u_fdrs_top (
      .clk(clk), .resetn(resetn), .soft_reset(soft_reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_oe_n(bus_oe_n),
      .mode_select(mode_select), .media_changed(media_changed),
      .transfer_engine_gate(transfer_engine_gate), .media_density_pin(media_density_pin),
      .rate_choice(rate_choice), .recal_active(recal_active), .step_pulse(step_pulse),
      .track_zero_pin(track_zero_pin), .relseek_past_zero(relseek_past_zero),
      .result_strobe(result_strobe), .result_info(result_info), .irq(irq)
   );

   fdrs_host u_fdrs_host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_oe_n(bus_oe_n)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test;
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic hw_reset(input fdrs_mode_type m);
      resetn <= 1'b0;
      mode_select <= m;
      tick(3);
      resetn <= 1'b1;
   endtask : hw_reset

   task automatic soft_pulse;
      soft_reset <= 1'b1;
      tick(1);
      soft_reset <= 1'b0;
      tick(1);
   endtask : soft_pulse

   task automatic steps(input int n);
      repeat (n) begin
         step_pulse <= 1'b1;
         tick(1);
         step_pulse <= 1'b0;
         tick(1);
      end
   endtask : steps

   task automatic capture(input fdrs_result_type info);
      result_info <= info;
      result_strobe <= 1'b1;
      tick(1);
      result_strobe <= 1'b0;
      tick(1);
   endtask : capture

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      u_fdrs_host.xfer(1'b0, a, 32'h0000_0000);
      `CHECK(u_fdrs_host.last_data & m, e)
   endtask : rd

   task automatic test_reset_values;
      `CHECK(rate_choice, 2'b10)
      `CHECK(media_density_pin, 1'b1)
      `CHECK(irq, 1'b0)
      rd(addr_in, 32'h0000_00fd, 32'hffff_ffff);
   endtask : test_reset_values

   task automatic test_mode_b;
      logic [1:0] r;
      logic lo;
      for (int i = 0; i < 4; i++) begin
         r = i[1:0];
         lo = (r == 2'b00) || (r == 2'b11);
         media_changed <= r[1];
         u_fdrs_host.rate_write(1'b0, r, 1'b0);
         tick(1);
         `CHECK(rate_choice, r)
         `CHECK(media_density_pin, lo)
         `CHECK(bus_oe_n, 8'hff)
         rd(addr_in, {24'h00_0000, ~r[1], 4'hf, r, ~lo}, 32'hffff_ffff);
         `CHECK(u_fdrs_host.last_oe, 8'h00)
         `CHECK(u_fdrs_host.last_err, 1'b0)
      end
   endtask : test_mode_b

   task automatic test_mode_a;
      hw_reset(FDRS_MODE_A);
      media_changed <= 1'b1;
      rd(addr_in, 32'h0000_0000, 32'h0000_0080);
      `CHECK(u_fdrs_host.last_oe, 8'h7f)
      media_changed <= 1'b0;
      rd(addr_in, 32'h0000_0080, 32'h0000_0080);
      u_fdrs_host.rate_write(1'b0, 2'b00, 1'b0);
      tick(1);
      `CHECK(rate_choice, 2'b00)
      u_fdrs_host.xfer(1'b0, 32'h0000_0ff0, 32'h0000_0000);
      `CHECK(u_fdrs_host.last_err, 1'b1)
      `CHECK(u_fdrs_host.last_data, 32'h0000_0000)
   endtask : test_mode_a

   task automatic test_mode_c;
      hw_reset(FDRS_MODE_C);
      transfer_engine_gate <= 1'b0;
      rd(addr_in, 32'h0000_0082, 32'hffff_ffff);
      u_fdrs_host.rate_write(1'b1, 2'b01, 1'b1);
      transfer_engine_gate <= 1'b1;
      rd(addr_in, 32'h0000_008d, 32'hffff_ffff);
      `CHECK(u_fdrs_host.last_oe, 8'h00)
      soft_pulse();
      rd(addr_in, 32'h0000_008d, 32'hffff_ffff);
      `CHECK(media_density_pin, 1'b0)
      hw_reset(FDRS_MODE_C);
      transfer_engine_gate <= 1'b0;
      tick(1);
      `CHECK(media_density_pin, 1'b1)
      rd(addr_in, 32'h0000_0082, 32'hffff_ffff);
   endtask : test_mode_c

   task automatic test_status;
      logic [1:0] r;
      for (int i = 0; i < 4; i++) begin
         r = i[1:0];
         capture({r, r[0], r[1], ~r});
         rd(addr_res, {24'h00_0000, r, r[0], 2'b00, r[1], ~r}, 32'hffff_ffff);
      end
      u_fdrs_host.xfer(1'b1, addr_res, 32'h0000_00ff);
      rd(addr_res, 32'h0000_00e4, 32'hffff_ffff);
      rd(addr_ist, 32'h0000_0006, 32'hffff_ffff);
      u_fdrs_host.xfer(1'b1, addr_msk, 32'h0000_0002);
      tick(3);
      `CHECK(irq, 1'b1)
      u_fdrs_host.xfer(1'b1, addr_ist, 32'h0000_0002);
      tick(3);
      `CHECK(irq, 1'b0)
      rd(addr_ist, 32'h0000_0004, 32'hffff_ffff);
      u_fdrs_host.xfer(1'b1, addr_msk, 32'h0000_0000);
   endtask : test_status

   task automatic test_fault;
      soft_pulse();
      track_zero_pin <= 1'b0;
      recal_active <= 1'b1;
      steps(79);
      capture(6'h00);
      rd(addr_res, 32'h0000_0000, 32'hffff_ffff);
      steps(1);
      capture(6'h00);
      rd(addr_res, 32'h0000_0010, 32'hffff_ffff);
      rd(addr_ist, 32'h0000_0005, 32'hffff_ffff);
      recal_active <= 1'b0;
      soft_pulse();
      track_zero_pin <= 1'b1;
      recal_active <= 1'b1;
      steps(80);
      capture(6'h00);
      rd(addr_res, 32'h0000_0000, 32'hffff_ffff);
      recal_active <= 1'b0;
      soft_pulse();
      relseek_past_zero <= 1'b1;
      tick(1);
      relseek_past_zero <= 1'b0;
      tick(1);
      capture(6'h00);
      rd(addr_res, 32'h0000_0010, 32'hffff_ffff);
   endtask : test_fault

   // A hung handshake would stall the sequence forever, so a bounded wait ends it.
   initial begin
      tick(20000);
      fails++;
      end_of_test();
   end

   initial begin
      resetn = 1'b0;
      soft_reset = 1'b0;
      mode_select = FDRS_MODE_B;
      media_changed = 1'b0;
      transfer_engine_gate = 1'b0;
      recal_active = 1'b0;
      step_pulse = 1'b0;
      track_zero_pin = 1'b1;
      relseek_past_zero = 1'b0;
      result_strobe = 1'b0;
      result_info = 6'h00;
      tick(10);
      resetn <= 1'b1;
      test_reset_values();
      test_mode_b();
      test_mode_a();
      test_mode_c();
      test_status();
      test_fault();
      end_of_test();
   end
endmodule : testbench
